// File: grps_pin_cell.sv
// One general-purpose pin: function decode with override terms
`timescale 1ns/1ns
module grps_pin_cell
	import grps_pkg::*;
(
	// Selection
	input  wire logic [1:0] fsel_in,
	input  wire logic       status_in,
	input  wire logic       force_drive_in,
	input  wire logic       drive_val_in,
	input  wire logic       force_input_in,
	// Next pin state
	output logic            out_next_out,
	output logic            oe_next_out
);
	wire grps_fn_type fn = grps_fn_type'(fsel_in);
	wire              fn_oe  = (fn != GRPS_FN_INPUT);
	wire              fn_val = (fn == GRPS_FN_HIGH) || ((fn == GRPS_FN_STATUS) && status_in);

	// Drive override beats everything, input force beats the select
	assign oe_next_out  = force_drive_in || (!force_input_in && fn_oe);
	assign out_next_out = force_drive_in ? drive_val_in : (!force_input_in && fn_val);
endmodule : grps_pin_cell

// File: grps_pkg.sv
// Constants, field layout and encodings of the global reference and pin select block
// Summary of operation
// R1 - Input select 0 and source 000: no 8 kHz reference, divider held disabled.
// R2 - Sources 001/010/011 take synthesizer DS3/E3/STS-1, else pins A/B/C when disabled.
// R3 - Clock synthesizer is disabled after reset, so pins A/B/C feed the reference.
// R4 - Sources 100 to 111 take ports 1 to 4 reference, each port-selected.
// R5 - Input select 1: pin 4 is the global 8 kHz input; source code ignored.
// R6 - Output select 1: pin 2 drives the reference; else its own function select.
// R7 - Input select 0: pin 4 follows its own two-bit function select.
// R8 - Unselected global 8 kHz input and reference signals are held low.
// R9 - Mode upper bits 00: pins A/B/C inputs; 01/10/11 make A a DS3/E3/STS-1 input.
// R10 - Pin A DS3: lower 00 both low, 01 E3 on B, 10 STS-1 on C, 11 swapped.
// R11 - Pin A E3: lower 00 both low, 01 DS3 on B, 10 STS-1 on C, 11 swapped.
// R12 - Pin A STS-1: lower 00 both low, 01 E3 on B, 10 DS3 on C, 11 swapped.
// R13 - Pin function 00 input, 10 drive low, 11 drive high.
// R14 - Function 01: odd pins show port A status, even pins port B status.
// R15 - Pin 8 function select applies only while global pin mode is not 01.
// R16 - Pin 6 function select applies only while its alternate-use bit is zero.
// R17 - Summary bit set while port status is set; enabled set bit drives interrupt low.
// R18 - All pin function selects reset to zero, so every pin starts as input.
package grps_pkg;
	// Register byte addresses
	localparam logic [7:0] GRPS_CR2_ADDR  = 8'h04;
	localparam logic [7:0] GRPS_FSEL_ADDR = 8'h0a;
	localparam logic [7:0] GRPS_ISR_ADDR  = 8'h10;
	localparam logic [7:0] GRPS_IEN_ADDR  = 8'h12;
	localparam logic [7:0] GRPS_AUX_ADDR  = 8'h20;
	localparam logic [7:0] GRPS_EVT_ADDR  = 8'h22;
	localparam logic [7:0] GRPS_EVM_ADDR  = 8'h24;
	localparam logic [7:0] GRPS_PIN_ADDR  = 8'h26;
	// Writable bit masks and reset values
	localparam logic [15:0] GRPS_CR2_MASK  = 16'h1f0f;
	localparam logic [15:0] GRPS_IEN_MASK  = 16'h00f3;
	localparam logic [15:0] GRPS_REG_RESET = 16'h0000;
	localparam logic [3:0]  GRPS_AUX_RESET = 4'h0;
	// Control field positions
	localparam int GRPS_SRC_LSB   = 10;
	localparam int GRPS_SRC_MSB   = 12;
	localparam int GRPS_OSEL_BIT  = 9;
	localparam int GRPS_ISEL_BIT  = 8;
	localparam int GRPS_MODE_MSB  = 3;
	localparam int GRPS_AUX_SYN   = 0;
	localparam int GRPS_AUX_GPM   = 1;
	localparam int GRPS_AUX_ALT6  = 3;
	localparam int GRPS_EVT_REF   = 0;
	localparam int GRPS_EVT_SUM   = 1;
	// Pin indices, zero based
	localparam int GRPS_PIN_REFO  = 1;
	localparam int GRPS_PIN_REFI  = 3;
	localparam int GRPS_PIN_ALT6  = 5;
	localparam int GRPS_PIN_GPM8  = 7;
	localparam logic [1:0] GRPS_GPM_BLOCK = 2'h1;
	typedef enum logic [2:0] {
		GRPS_SRC_NONE = 3'h0,
		GRPS_SRC_DS3  = 3'h1,
		GRPS_SRC_E3   = 3'h2,
		GRPS_SRC_STS1 = 3'h3,
		GRPS_SRC_P1   = 3'h4,
		GRPS_SRC_P2   = 3'h5,
		GRPS_SRC_P3   = 3'h6,
		GRPS_SRC_P4   = 3'h7
	} grps_src_type;
	typedef enum logic [1:0] {
		GRPS_FN_INPUT  = 2'h0,
		GRPS_FN_STATUS = 2'h1,
		GRPS_FN_LOW    = 2'h2,
		GRPS_FN_HIGH   = 2'h3
	} grps_fn_type;
	// Synthesizer pin mode upper and lower field codes
	localparam logic [1:0] GRPS_UP_IN   = 2'h0;
	localparam logic [1:0] GRPS_UP_DS3  = 2'h1;
	localparam logic [1:0] GRPS_UP_E3   = 2'h2;
	localparam logic [1:0] GRPS_UP_STS1 = 2'h3;
	localparam logic [1:0] GRPS_LO_LOW  = 2'h0;
	localparam logic [1:0] GRPS_LO_B    = 2'h1;
	localparam logic [1:0] GRPS_LO_C    = 2'h2;
	localparam logic [1:0] GRPS_LO_SWAP = 2'h3;
endpackage : grps_pkg

// File: grps_top.sv
// Global 8 kHz reference source, synthesizer pin and general-purpose pin select logic
`timescale 1ns/1ns
module grps_top
	import grps_pkg::*;
#(
	parameter int PINS  = 8,
	parameter int PORTS = 4
) (
	// Clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             nrst_in,
	// Register port
	input  wire logic [7:0]       addr_in,
	input  wire logic [15:0]      wr_data_in,
	input  wire logic             wr_en_in,
	input  wire logic             rd_en_in,
	output logic [15:0]           rd_data_out,
	// Synthesizer clocks and pins
	input  wire logic             synth_ds3_in,
	input  wire logic             synth_e3_in,
	input  wire logic             synth_sts1_in,
	input  wire logic             synth_pin_a_in,
	input  wire logic             synth_pin_b_in,
	input  wire logic             synth_pin_c_in,
	output logic                  synth_pin_a_out,
	output logic                  synth_pin_a_oe_out,
	output logic                  synth_pin_b_out,
	output logic                  synth_pin_b_oe_out,
	output logic                  synth_pin_c_out,
	output logic                  synth_pin_c_oe_out,
	// Port references and status
	input  wire logic [PORTS-1:0] port_ref_in,
	input  wire logic [PORTS-1:0] port_status_a_in,
	input  wire logic [PORTS-1:0] port_status_b_in,
	input  wire logic [PORTS-1:0] port_interrupt_summary_in,
	input  wire logic             tx_system_status_summary_in,
	input  wire logic             global_status_summary_in,
	// General-purpose pins
	input  wire logic [PINS-1:0]  gpio_in,
	output logic [PINS-1:0]       gpio_out,
	output logic [PINS-1:0]       gpio_oe_out,
	// Reference outputs
	output logic                  eight_khz_reference_out,
	output logic                  global_ref_input_out,
	output logic                  ref_divider_enable_out,
	// Interrupts
	output logic                  int_n_out,
	output logic                  irq_out
);
	import grps_pkg::*;

	logic [15:0] cr2_reg;
	logic [15:0] fsel_reg;
	logic [15:0] ien_reg;
	logic [3:0]  aux_reg;
	logic [1:0]  evt_reg;
	logic [1:0]  evm_reg;
	logic        sum_prev_reg;
	logic [15:0] rd_next;
	logic        int_ref;
	logic        clk_p;
	logic        clk_q;

	// Decoding
	wire wr_cr2  = wr_en_in && (addr_in == GRPS_CR2_ADDR);
	wire wr_fsel = wr_en_in && (addr_in == GRPS_FSEL_ADDR);
	wire wr_ien  = wr_en_in && (addr_in == GRPS_IEN_ADDR);
	wire wr_aux  = wr_en_in && (addr_in == GRPS_AUX_ADDR);
	wire wr_evt  = wr_en_in && (addr_in == GRPS_EVT_ADDR);
	wire wr_evm  = wr_en_in && (addr_in == GRPS_EVM_ADDR);

	wire grps_src_type src_sel = grps_src_type'(cr2_reg[GRPS_SRC_MSB:GRPS_SRC_LSB]);
	wire       in_sel   = cr2_reg[GRPS_ISEL_BIT];
	wire       out_sel  = cr2_reg[GRPS_OSEL_BIT];
	wire [1:0] io_up    = cr2_reg[GRPS_MODE_MSB -: 2];
	wire [1:0] io_lo    = cr2_reg[GRPS_MODE_MSB-2 -: 2];
	wire       synth_en = aux_reg[GRPS_AUX_SYN];
	wire [1:0] gpm      = aux_reg[GRPS_AUX_GPM +: 2];
	wire       alt6     = aux_reg[GRPS_AUX_ALT6];

	// Disabled synthesizer falls back to the external clock pins
	wire ds3_src  = synth_en ? synth_ds3_in : synth_pin_a_in;    // R2 R3
	wire e3_src   = synth_en ? synth_e3_in : synth_pin_b_in;     // R2 R3
	wire sts1_src = synth_en ? synth_sts1_in : synth_pin_c_in;   // R2 R3

	always_comb begin
		case (src_sel)
			GRPS_SRC_NONE: int_ref = 1'b0;                          // R1
			GRPS_SRC_DS3:  int_ref = ds3_src;                       // R2
			GRPS_SRC_E3:   int_ref = e3_src;                        // R2
			GRPS_SRC_STS1: int_ref = sts1_src;                      // R2
			GRPS_SRC_P1:   int_ref = port_ref_in[0];                // R4
			GRPS_SRC_P2:   int_ref = port_ref_in[1];                // R4
			GRPS_SRC_P3:   int_ref = port_ref_in[2];                // R4
			GRPS_SRC_P4:   int_ref = port_ref_in[3];                // R4
			default:       int_ref = 1'b0;
		endcase
	end

	// Pin 4 input overrides the source code entirely
	wire ref_next    = in_sel ? gpio_in[GRPS_PIN_REFI] : int_ref;     // R5
	wire refi_next   = in_sel & gpio_in[GRPS_PIN_REFI];               // R5 R8
	wire div_en_next = in_sel | (src_sel != GRPS_SRC_NONE);           // R1

	// Clock offered on pin B in code 01 (p) and on pin C in code 10 (q)
	always_comb begin
		case (io_up)
			GRPS_UP_DS3: begin
				clk_p = synth_e3_in;                                      // R10
				clk_q = synth_sts1_in;
			end
			GRPS_UP_E3: begin
				clk_p = synth_ds3_in;                                     // R11
				clk_q = synth_sts1_in;
			end
			GRPS_UP_STS1: begin
				clk_p = synth_e3_in;                                      // R12
				clk_q = synth_ds3_in;
			end
			default: begin
				clk_p = 1'b0;
				clk_q = 1'b0;
			end
		endcase
	end

	// Code 11 swaps: B carries q, C carries p
	wire bc_oe_next = (io_up != GRPS_UP_IN);                                            // R9
	wire b_next = (io_lo == GRPS_LO_B) ? clk_p : ((io_lo == GRPS_LO_SWAP) ? clk_q : 1'b0); // R10 R11 R12
	wire c_next = (io_lo == GRPS_LO_C) ? clk_q : ((io_lo == GRPS_LO_SWAP) ? clk_p : 1'b0); // R10 R11 R12

	// General-purpose pins
	logic [PINS-1:0] pin_out_next;
	logic [PINS-1:0] pin_oe_next;

	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_pin
			// Even index is an odd pin number and carries A status
			wire st = (gi % 2 == 0) ? port_status_a_in[gi/2] : port_status_b_in[gi/2];   // R14
			wire fd = (gi == GRPS_PIN_REFO) && out_sel;                                    // R6
			wire fi = ((gi == GRPS_PIN_REFI) && in_sel)                                     // R7
				|| ((gi == GRPS_PIN_GPM8) && (gpm == GRPS_GPM_BLOCK))                      // R15
				|| ((gi == GRPS_PIN_ALT6) && alt6);                                        // R16
			grps_pin_cell u_cell (
				.fsel_in        (fsel_reg[2*gi +: 2]),
				.status_in      (st),
				.force_drive_in (fd),
				.drive_val_in   (ref_next),
				.force_input_in (fi),
				.out_next_out   (pin_out_next[gi]),
				.oe_next_out    (pin_oe_next[gi])
			);
		end
	endgenerate

	// Interrupt summary, recomputed from the live sources
	wire [15:0] isr_val = {8'h00, port_interrupt_summary_in, 2'b00,
		tx_system_status_summary_in, global_status_summary_in};                     // R17
	wire        sum_any = |isr_val;
	wire        int_next = ~|(isr_val & ien_reg);                                   // R17

	// Sticky events: the set term wins over a same-cycle clear
	wire [1:0] evt_set;
	assign evt_set[GRPS_EVT_REF] = ref_next & ~eight_khz_reference_out;
	assign evt_set[GRPS_EVT_SUM] = sum_any & ~sum_prev_reg;
	wire [1:0] evt_clr  = wr_evt ? wr_data_in[1:0] : 2'b00;
	wire [1:0] evt_next = (evt_reg & ~evt_clr) | evt_set;

	// Read selection; unmapped addresses read zero
	always_comb begin
		case (addr_in)
			GRPS_CR2_ADDR:  rd_next = cr2_reg;
			GRPS_FSEL_ADDR: rd_next = fsel_reg;
			GRPS_ISR_ADDR:  rd_next = isr_val;
			GRPS_IEN_ADDR:  rd_next = ien_reg;
			GRPS_AUX_ADDR:  rd_next = {12'h000, aux_reg};
			GRPS_EVT_ADDR:  rd_next = {14'h0000, evt_reg};
			GRPS_EVM_ADDR:  rd_next = {14'h0000, evm_reg};
			GRPS_PIN_ADDR:  rd_next = {{(16-PINS){1'b0}}, gpio_in};
			default:        rd_next = 16'h0000;
		endcase
	end

	// Register file
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cr2_reg  <= GRPS_REG_RESET;
			fsel_reg <= GRPS_REG_RESET;                               // R18
			ien_reg  <= GRPS_REG_RESET;
			aux_reg  <= GRPS_AUX_RESET;                               // R3
			evm_reg  <= 2'h0;
		end else begin
			if (wr_cr2)
				cr2_reg <= wr_data_in & GRPS_CR2_MASK;
			if (wr_fsel)
				fsel_reg <= wr_data_in;
			if (wr_ien)
				ien_reg <= wr_data_in & GRPS_IEN_MASK;
			if (wr_aux)
				aux_reg <= wr_data_in[3:0];
			if (wr_evm)
				evm_reg <= wr_data_in[1:0];
		end
	end

	// Status and read data
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			evt_reg      <= 2'h0;
			sum_prev_reg <= 1'b0;
			rd_data_out  <= 16'h0000;
			irq_out      <= 1'b0;
			int_n_out    <= 1'b1;
		end else begin
			evt_reg      <= evt_next;
			sum_prev_reg <= sum_any;
			rd_data_out  <= rd_en_in ? rd_next : 16'h0000;
			irq_out      <= |(evt_next & evm_reg);
			int_n_out    <= int_next;                                 // R17
		end
	end

	// Pin and reference outputs; one flop stage on every path
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			gpio_out                <= '0;
			gpio_oe_out             <= '0;
			synth_pin_a_out         <= 1'b0;
			synth_pin_a_oe_out      <= 1'b0;
			synth_pin_b_out         <= 1'b0;
			synth_pin_b_oe_out      <= 1'b0;
			synth_pin_c_out         <= 1'b0;
			synth_pin_c_oe_out      <= 1'b0;
			eight_khz_reference_out <= 1'b0;
			global_ref_input_out    <= 1'b0;
			ref_divider_enable_out  <= 1'b0;
		end else begin
			gpio_out                <= pin_out_next;                  // R13 R14
			gpio_oe_out             <= pin_oe_next;                   // R13
			synth_pin_a_out         <= 1'b0;
			synth_pin_a_oe_out      <= 1'b0;                          // R9
			synth_pin_b_out         <= bc_oe_next & b_next;
			synth_pin_b_oe_out      <= bc_oe_next;                    // R9
			synth_pin_c_out         <= bc_oe_next & c_next;
			synth_pin_c_oe_out      <= bc_oe_next;                    // R9
			eight_khz_reference_out <= ref_next;
			global_ref_input_out    <= refi_next;                     // R8
			ref_divider_enable_out  <= div_en_next;                   // R1
		end
	end

	// Checks
	sequence s_clear_on_set;
		wr_evt && wr_data_in[GRPS_EVT_REF] && evt_set[GRPS_EVT_REF];
	endsequence

	sequence s_ref_idle;
		!in_sel && (src_sel == GRPS_SRC_NONE);
	endsequence

	property p_none_idle;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		s_ref_idle ##1 s_ref_idle |-> !ref_divider_enable_out && !eight_khz_reference_out;
	endproperty
	a_none_idle: assert property (p_none_idle) else $error("reference active with no source"); // R1

	property p_ds3_fallback;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(!in_sel && src_sel == GRPS_SRC_DS3 && !synth_en) |=> (eight_khz_reference_out == $past(synth_pin_a_in));
	endproperty
	a_ds3_fallback: assert property (p_ds3_fallback) else $error("DS3 source not from pin A"); // R2

	property p_port_src;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(!in_sel && src_sel == GRPS_SRC_P3) |=> (eight_khz_reference_out == $past(port_ref_in[2]));
	endproperty
	a_port_src: assert property (p_port_src) else $error("port 3 reference not selected"); // R4

	property p_pin4_ref;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		in_sel |=> (eight_khz_reference_out == $past(gpio_in[GRPS_PIN_REFI]))
			&& (global_ref_input_out == eight_khz_reference_out) && !gpio_oe_out[GRPS_PIN_REFI];
	endproperty
	a_pin4_ref: assert property (p_pin4_ref) else $error("pin 4 reference input wrong"); // R5

	property p_pin2_ref;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		out_sel |=> gpio_oe_out[GRPS_PIN_REFO] && (gpio_out[GRPS_PIN_REFO] == eight_khz_reference_out);
	endproperty
	a_pin2_ref: assert property (p_pin2_ref) else $error("pin 2 not driving reference"); // R6

	property p_refi_low;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		!in_sel |=> !global_ref_input_out;
	endproperty
	a_refi_low: assert property (p_refi_low) else $error("global input not held low"); // R8

	property p_b_e3;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(io_up == GRPS_UP_DS3 && io_lo == GRPS_LO_B) |=>
			synth_pin_b_oe_out && synth_pin_c_oe_out && !synth_pin_c_out && (synth_pin_b_out == $past(synth_e3_in));
	endproperty
	a_b_e3: assert property (p_b_e3) else $error("pin B not carrying E3"); // R10

	property p_c_ds3_swap;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(io_up == GRPS_UP_E3 && io_lo == GRPS_LO_SWAP) |=> (synth_pin_c_out == $past(synth_ds3_in))
			&& (synth_pin_b_out == $past(synth_sts1_in));
	endproperty
	a_c_ds3_swap: assert property (p_c_ds3_swap) else $error("E3 swap mode wrong"); // R11

	property p_pin1_low;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(fsel_reg[1:0] == GRPS_FN_LOW) |=> gpio_oe_out[0] && !gpio_out[0];
	endproperty
	a_pin1_low: assert property (p_pin1_low) else $error("pin 1 not driven low"); // R13

	property p_pin8_block;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(gpm == GRPS_GPM_BLOCK) |=> !gpio_oe_out[GRPS_PIN_GPM8];
	endproperty
	a_pin8_block: assert property (p_pin8_block) else $error("pin 8 driven while blocked"); // R15

	property p_pin6_alt;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		alt6 |=> !gpio_oe_out[GRPS_PIN_ALT6];
	endproperty
	a_pin6_alt: assert property (p_pin6_alt) else $error("pin 6 driven in alternate use"); // R16

	property p_int_low;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		(port_interrupt_summary_in[1] && ien_reg[5]) |=> !int_n_out;
	endproperty
	a_int_low: assert property (p_int_low) else $error("interrupt not asserted"); // R17

	property p_set_wins;
		@(posedge ref_clk_in) disable iff (!nrst_in)
		s_clear_on_set |=> evt_reg[GRPS_EVT_REF];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost on clear");
endmodule : grps_top

// File: test_global_ref_clock_pin_select.sv
// Self-checking testbench of the global reference and pin select block
`timescale 1ns/1ns
module test_global_ref_clock_pin_select;
	import grps_pkg::*;
	logic        ref_clk, nrst, wr_en, rd_en, tx_sum, gl_sum;
	logic [7:0]  addr, gpio_i, gpio_o, gpio_oe;
	logic [15:0] wr_data, rd_data, rd_val;
	logic        syn_ds3, syn_e3, syn_sts1, pin_a, pin_b, pin_c;
	logic        pa_o, pa_oe, pb_o, pb_oe, pc_o, pc_oe;
	logic [3:0]  port_ref, st_a, st_b, pis;
	logic        ref_o, refi_o, div_en, int_n, irq;
	int          mismatches, checks;

	grps_top u_grps_top (.ref_clk_in(ref_clk), .nrst_in(nrst), .addr_in(addr), .wr_data_in(wr_data),
		.wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data), .synth_ds3_in(syn_ds3),
		.synth_e3_in(syn_e3), .synth_sts1_in(syn_sts1), .synth_pin_a_in(pin_a), .synth_pin_b_in(pin_b),
		.synth_pin_c_in(pin_c), .synth_pin_a_out(pa_o), .synth_pin_a_oe_out(pa_oe), .synth_pin_b_out(pb_o),
		.synth_pin_b_oe_out(pb_oe), .synth_pin_c_out(pc_o), .synth_pin_c_oe_out(pc_oe),
		.port_ref_in(port_ref), .port_status_a_in(st_a), .port_status_b_in(st_b),
		.port_interrupt_summary_in(pis), .tx_system_status_summary_in(tx_sum),
		.global_status_summary_in(gl_sum), .gpio_in(gpio_i), .gpio_out(gpio_o), .gpio_oe_out(gpio_oe),
		.eight_khz_reference_out(ref_o), .global_ref_input_out(refi_o), .ref_divider_enable_out(div_en),
		.int_n_out(int_n), .irq_out(irq));

	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Returns one edge after the register edge, so outputs already show the new value
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask : wr

	task automatic chkrd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		check(rd_data, exp);
	endtask : chkrd

	// Vector order: ports 4..1, pins C B A, synthesizer STS-1 E3 DS3
	task automatic set_src(input logic [9:0] v, input logic [7:0] g);
		@(posedge ref_clk);
		{port_ref, pin_c, pin_b, pin_a, syn_sts1, syn_e3, syn_ds3} <= v;
		gpio_i <= g;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : set_src

	task automatic t_regs;
		chkrd(GRPS_FSEL_ADDR, 16'h0000);
		check(gpio_oe, 16'h0000);
		chkrd(GRPS_AUX_ADDR, 16'h0000);
		check(div_en, 1'b0);
		check(int_n, 1'b1);
		wr(GRPS_CR2_ADDR, 16'hffff);
		chkrd(GRPS_CR2_ADDR, GRPS_CR2_MASK);
		wr(GRPS_IEN_ADDR, 16'hffff);
		chkrd(GRPS_IEN_ADDR, GRPS_IEN_MASK);
		wr(GRPS_FSEL_ADDR, 16'ha5c3);
		chkrd(GRPS_FSEL_ADDR, 16'ha5c3);
		wr(GRPS_CR2_ADDR, 16'h0000);
		wr(GRPS_IEN_ADDR, 16'h0000);
		wr(GRPS_FSEL_ADDR, 16'h0000);
	endtask : t_regs

	// Synthesizer disabled first, so codes 1 to 3 must follow the pins
	task automatic t_source;
		int idx;
		for (int en = 0; en < 2; en++) begin
			wr(GRPS_AUX_ADDR, 16'(en));
			for (int s = 0; s < 8; s++) begin
				wr(GRPS_CR2_ADDR, 16'(s) << 10);
				idx = (s < 4 && en == 1) ? s - 1 : s + 2;
				if (s == 0) begin
					set_src(10'h3ff, 8'h00);
					check(ref_o, 1'b0);
					check(div_en, 1'b0);
				end else begin
					set_src(10'h001 << idx, 8'h00);
					check(ref_o, 1'b1);
					check(div_en, 1'b1);
					set_src(~(10'h001 << idx), 8'h00);
					check(ref_o, 1'b0);
				end
			end
		end
		wr(GRPS_AUX_ADDR, 16'h0000);
	endtask : t_source

	task automatic t_pin4;
		wr(GRPS_FSEL_ADDR, 16'hffff);
		wr(GRPS_CR2_ADDR, 16'h0500);
		set_src(10'h3ff, 8'h00);
		check(ref_o, 1'b0);
		check(refi_o, 1'b0);
		check(gpio_oe[3], 1'b0);
		check(div_en, 1'b1);
		set_src(10'h000, 8'h08);
		check({ref_o, refi_o}, 2'b11);
		chkrd(GRPS_PIN_ADDR, 16'h0008);
		wr(GRPS_CR2_ADDR, 16'h0000);
		check(refi_o, 1'b0);
		check({gpio_oe[3], gpio_o[3]}, 2'b11);
		wr(GRPS_FSEL_ADDR, 16'h0000);
		set_src(10'h000, 8'h00);
	endtask : t_pin4

	task automatic t_pin2;
		wr(GRPS_FSEL_ADDR, 16'h0008);
		wr(GRPS_CR2_ADDR, 16'h1200);
		set_src(10'h040, 8'h00);
		check({ref_o, gpio_oe[1], gpio_o[1]}, 3'b111);
		set_src(10'h000, 8'h00);
		check({gpio_oe[1], gpio_o[1]}, 2'b10);
		wr(GRPS_CR2_ADDR, 16'h1000);
		set_src(10'h040, 8'h00);
		check({gpio_oe[1], gpio_o[1]}, 2'b10);
		wr(GRPS_CR2_ADDR, 16'h0000);
		wr(GRPS_FSEL_ADDR, 16'h0000);
		set_src(10'h000, 8'h00);
	endtask : t_pin2

	// One-hot synthesizer clocks tell apart which clock reaches each pin
	task automatic t_synth;
		logic [1:0] u;
		logic [1:0] l;
		logic [2:0] v;
		logic       p, q, eb, ec;
		for (int m = 0; m < 16; m++) begin
			wr(GRPS_CR2_ADDR, 16'(m));
			u = 2'(m >> 2);
			l = 2'(m);
			for (int k = 0; k < 3; k++) begin
				v = 3'h1 << k;
				set_src({7'h00, v}, 8'h00);
				p = (u == 2'h2) ? v[0] : v[1];
				q = (u == 2'h3) ? v[0] : v[2];
				eb = (l == 2'h1) ? p : (l == 2'h3) ? q : 1'b0;
				ec = (l == 2'h2) ? q : (l == 2'h3) ? p : 1'b0;
				check({pa_oe, pb_oe, pc_oe}, {1'b0, u != 2'h0, u != 2'h0});
				check(pa_o, 1'b0);
				if (u != 2'h0) check({pb_o, pc_o}, {eb, ec});
			end
		end
		wr(GRPS_CR2_ADDR, 16'h0000);
	endtask : t_synth

	task automatic t_gpio;
		logic [7:0] oe_e, out_e;
		@(posedge ref_clk);
		st_a <= 4'b0110;
		st_b <= 4'b0011;
		for (int c = 0; c < 4; c++) begin
			wr(GRPS_FSEL_ADDR, {8{c[1:0]}});
			for (int i = 0; i < 8; i++) begin
				oe_e[i] = (c != 0);
				out_e[i] = (c == 3) ? 1'b1 : (c == 1) ? ((i % 2 == 0) ? st_a[i/2] : st_b[i/2]) : 1'b0;
			end
			check({gpio_oe, gpio_o & gpio_oe}, {oe_e, out_e});
		end
		wr(GRPS_AUX_ADDR, 16'h0002);
		check(gpio_oe, 16'h007f);
		wr(GRPS_AUX_ADDR, 16'h0004);
		check(gpio_oe, 16'h00ff);
		wr(GRPS_AUX_ADDR, 16'h0008);
		check(gpio_oe, 16'h00df);
		wr(GRPS_AUX_ADDR, 16'h0000);
		wr(GRPS_FSEL_ADDR, 16'h0000);
	endtask : t_gpio

	// Clear strobe lands on the edge where the reference rises; the set must win
	task automatic t_setwin;
		wr(GRPS_CR2_ADDR, 16'h1000);
		@(posedge ref_clk);
		addr     <= GRPS_EVT_ADDR;
		wr_data  <= 16'h0001;
		wr_en    <= 1'b1;
		port_ref <= 4'h1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
		chkrd(GRPS_EVT_ADDR, 16'h0001);
		wr(GRPS_CR2_ADDR, 16'h0000);
		set_src(10'h000, 8'h00);
	endtask : t_setwin

	task automatic t_irq;
		@(posedge ref_clk);
		pis    <= 4'h0;
		tx_sum <= 1'b0;
		gl_sum <= 1'b0;
		wr(GRPS_EVT_ADDR, 16'h0003);
		chkrd(GRPS_EVT_ADDR, 16'h0000);
		wr(GRPS_EVM_ADDR, 16'h0002);
		check(irq, 1'b0);
		@(posedge ref_clk);
		pis    <= 4'b1010;
		tx_sum <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chkrd(GRPS_ISR_ADDR, 16'h00a2);
		check(int_n, 1'b1);
		wr(GRPS_IEN_ADDR, 16'h0020);
		check(int_n, 1'b0);
		wr(GRPS_IEN_ADDR, 16'h0051);
		check(int_n, 1'b1);
		wr(GRPS_IEN_ADDR, 16'h0002);
		check(int_n, 1'b0);
		wr(GRPS_IEN_ADDR, 16'h0000);
		chkrd(GRPS_EVT_ADDR, 16'h0002);
		check(irq, 1'b1);
		wr(GRPS_EVM_ADDR, 16'h0000);
		check(irq, 1'b0);
		wr(GRPS_EVM_ADDR, 16'h0002);
		check(irq, 1'b1);
		wr(GRPS_EVT_ADDR, 16'h0002);
		check(irq, 1'b0);
		chkrd(GRPS_EVT_ADDR, 16'h0000);
		wr(GRPS_ISR_ADDR, 16'hffff);
		chkrd(GRPS_ISR_ADDR, 16'h00a2);
		chkrd(8'h3e, 16'h0000);
	endtask : t_irq

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	// Whole run takes well under 3000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		end_of_test();
	end

	initial begin
		mismatches = 0;
		checks = 0;
		nrst = 1'b0;
		{wr_en, rd_en, addr, wr_data} = '0;
		{port_ref, pin_c, pin_b, pin_a, syn_sts1, syn_e3, syn_ds3} = '0;
		{st_a, st_b, pis, tx_sum, gl_sum, gpio_i} = '0;
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		t_regs();
		t_source();
		t_pin4();
		t_pin2();
		t_synth();
		t_gpio();
		t_setwin();
		t_irq();
		end_of_test();
	end
endmodule : test_global_ref_clock_pin_select
